// *** include/drive_supervisor_pkg.sv ***
package drive_supervisor_pkg;

   // axi4-lite register byte offsets
   localparam logic [7:0] CTRL_OFFSET      = 8'h00;
   localparam logic [7:0] STATUS_OFFSET    = 8'h04;
   localparam logic [7:0] IRQ_STAT_OFFSET  = 8'h08;
   localparam logic [7:0] IRQ_MASK_OFFSET  = 8'h0c;
   localparam logic [7:0] MON_TIME_OFFSET  = 8'h10;

   // ctrl fields
   localparam int CTRL_REQ_X_BIT      = 0;
   localparam int CTRL_REQ_Y_BIT      = 1;
   localparam int CTRL_LOCAL_BIT      = 2;
   localparam int CTRL_JOG_DIS_BIT    = 3;
   localparam int CTRL_RESTART_BIT    = 4;

   // irq status / irq mask fields
   localparam int EV_FB_TIMEOUT_BIT   = 0;
   localparam int EV_FB_LOST_BIT      = 1;
   localparam int EV_TORQUE_BIT       = 2;
   localparam int EV_LIMIT_BIT        = 3;
   localparam int EV_SAFETY_BIT       = 4;
   localparam int EV_MACHINE_BIT      = 5;
   localparam int EV_END_POS_BIT      = 6;
   localparam int EV_WIDTH            = 7;

   localparam logic [31:0] CTRL_RESET      = 32'h0000_0008;
   localparam logic [31:0] IRQ_MASK_RESET  = 32'h0000_0000;

   // feedback monitoring time, milliseconds, default
   localparam int MON_TIME_MS         = 2;
   localparam int CLK_PERIOD_NS       = 10;
   localparam int MON_TIME_CYCLES     = MON_TIME_MS * 1000000 / CLK_PERIOD_NS;
   localparam logic [31:0] MON_TIME_RESET = 32'(MON_TIME_CYCLES);

   localparam logic [1:0] RESP_OKAY   = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   typedef enum {
      ST_IDLE,
      ST_STARTING,
      ST_RUNNING,
      ST_FAILED
   } drive_state_type;

   // per-direction field inputs
   typedef struct packed {
      logic run_feedback;
      logic torque_permissive;
      logic limit_permissive;
      logic end_position;
      logic local_start_button;
   } dir_field_type;

   typedef struct packed {
      logic          request_x;
      logic          request_y;
      logic          local_mode;
      logic          jog_disable_param;
      logic          restart;
      logic [31:0]   feedback_monitor_time;
   } drive_ctrl_type;

endpackage : drive_supervisor_pkg

// *** sim/bidirectional_drive_supervisor_tb_top.sv ***
`timescale 1ns/100ps
module bidirectional_drive_supervisor_tb_top
   import drive_supervisor_pkg::*;
;
   localparam int LIMIT = 8000;
   logic          clk, reset_n, parent_group_restart, irq, failed;
   logic [7:0]    s_axi_awaddr, s_axi_araddr;
   logic [31:0]   s_axi_wdata, s_axi_rdata, d;
   logic [3:0]    s_axi_wstrb;
   logic [1:0]    s_axi_bresp, s_axi_rresp, resp;
   logic          s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic          s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic          s_axi_rvalid, s_axi_rready, local_start_button;
   logic          dir_run_feedback_x, dir_run_feedback_y, stuck, drop_x;
   logic          safety_interlock_ok, machine_protection_ok;
   logic          dir_run_command_x, dir_run_command_y;
   dir_field_type fx, fy;
   int            n, cycles, err_total, n_tests;

   bidirectional_drive_supervisor dut
   (
      .dir_torque_permissive_x  (fx.torque_permissive),
      .dir_torque_permissive_y  (fy.torque_permissive),
      .dir_limit_permissive_x   (fx.limit_permissive),
      .dir_limit_permissive_y   (fy.limit_permissive),
      .dir_end_position_x       (fx.end_position),
      .dir_end_position_y       (fy.end_position),
      .local_start_button_dir_x (fx.local_start_button),
      .local_start_button_dir_y (fy.local_start_button),
      .*
   );

   field_contactors partner
   (
      .clk    (clk),
      .cmd_x  (dir_run_command_x),
      .cmd_y  (dir_run_command_y),
      .stuck  (stuck),
      .drop_x (drop_x),
      .fb_x   (dir_run_feedback_x),
      .fb_y   (dir_run_feedback_y)
   );

   initial
   begin
      clk = 1'h0;
      forever #5 clk = ~clk;
   end

   always @(posedge clk)
   begin
      cycles <= cycles + 1;
      if (cycles == LIMIT)
      begin
         err_total++;
         conclude();
      end
   end

   task automatic conclude;
      $display("comparisons %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : conclude

   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      n_tests++;
      if (g !== e)
      begin
         err_total++;
         $display("wrong value %s expected %0h seen %0h", nm, e, g);
      end
   endtask : chk

   task automatic cyc(input int k);
      repeat (k) @(posedge clk);
   endtask : cyc

   task automatic wait_fail(input int lim);
      n = 0;
      while (failed !== 1'h1 && n < lim)
      begin
         @(posedge clk);
         n++;
      end
   endtask : wait_fail

   // bready and rready stay high, so an answer is taken at its first edge
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      s_axi_awaddr  <= a;
      s_axi_wdata   <= v;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid  <= 1'h1;
      do
      begin
         @(posedge clk);
         if (s_axi_awready)
            s_axi_awvalid <= 1'h0;
         if (s_axi_wready)
            s_axi_wvalid <= 1'h0;
      end
      while (s_axi_bvalid !== 1'h1);
      chk("bresp", RESP_OKAY, s_axi_bresp);
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [31:0] v);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'h1;
      do
      begin
         @(posedge clk);
         if (s_axi_arready)
            s_axi_arvalid <= 1'h0;
      end
      while (s_axi_rvalid !== 1'h1);
      v    = s_axi_rdata;
      resp = s_axi_rresp;
   endtask : rd

   task automatic recover(input logic by_reg);
      wr(CTRL_OFFSET, {27'h0, by_reg, 4'h0});
      parent_group_restart <= !by_reg;
      cyc(4);
      parent_group_restart <= 1'h0;
      cyc(4);
      wr(IRQ_STAT_OFFSET, 32'h0000_007f);
      cyc(2);
      chk("failed", 0, failed);
      chk("irq", 0, irq);
   endtask : recover

   task automatic run_end;
      wr(CTRL_OFFSET, 32'h0000_0001);
      cyc(40);
      chk("cmd_x", 1, dir_run_command_x);
      chk("cmd_y", 0, dir_run_command_y);
      rd(STATUS_OFFSET, d);
      chk("running", 1, d[4]);
      fx.end_position <= 1'h1;
      cyc(8);
      chk("cmd_x", 0, dir_run_command_x);
      chk("failed", 0, failed);
      chk("irq", 1, irq);
      rd(IRQ_STAT_OFFSET, d);
      chk("end_event", 1, d[EV_END_POS_BIT]);
      wr(CTRL_OFFSET, 32'h0000_0000);
      fx.end_position <= 1'h0;
      recover(1'h1);
   endtask : run_end

   task automatic no_feedback;
      wr(IRQ_MASK_OFFSET, 32'h0000_0000);
      stuck <= 1'h1;
      wr(CTRL_OFFSET, 32'h0000_0002);
      wait_fail(80);
      chk("fail_late", 1, n >= 20);
      chk("failed", 1, failed);
      chk("cmd_y", 0, dir_run_command_y);
      chk("irq_masked", 0, irq);
      wr(IRQ_MASK_OFFSET, 32'h0000_007f);
      cyc(2);
      chk("irq", 1, irq);
      rd(IRQ_STAT_OFFSET, d);
      chk("timeout_event", 1, d[EV_FB_TIMEOUT_BIT]);
      stuck <= 1'h0;
      recover(1'h0);
   endtask : no_feedback

   // k: 0 feedback, 1 safety, 2 torque x, 3 limit x
   task automatic run_fault(input logic [1:0] k);
      wr(CTRL_OFFSET, 32'h0000_0001);
      cyc(40);
      chk("cmd_x", 1, dir_run_command_x);
      drop_x <= (k == 2'h0);
      safety_interlock_ok <= (k != 2'h1);
      fx <= (k == 2'h2) ? 5'h04 : (k == 2'h3) ? 5'h08 : 5'h0c;
      wait_fail(10);
      chk("failed", 1, failed);
      {drop_x, safety_interlock_ok} <= 2'h1;
      fx <= 5'h0c;
      cyc(20);
      chk("failed_held", 1, failed);
      chk("cmd_x", 0, dir_run_command_x);
      recover(k[0]);
   endtask : run_fault

   task automatic blocked(input logic [31:0] c);
      wr(CTRL_OFFSET, c);
      cyc(30);
      chk("cmds", 0, {dir_run_command_x, dir_run_command_y});
      chk("failed", 0, failed);
      wr(CTRL_OFFSET, 32'h0000_0000);
      {fy, safety_interlock_ok, machine_protection_ok} <= 7'h33;
      {fx, local_start_button} <= 6'h18;
      cyc(2);
   endtask : blocked

   task automatic jog;
      machine_protection_ok <= 1'h0;
      fx.local_start_button <= 1'h1;
      wr(CTRL_OFFSET, 32'h0000_0005);
      cyc(40);
      chk("cmd_x", 1, dir_run_command_x);
      fx.local_start_button <= 1'h0;
      wait_fail(10);
      chk("failed", 1, failed);
      machine_protection_ok <= 1'h1;
      recover(1'h1);
   endtask : jog

   initial
   begin
      {reset_n, parent_group_restart, local_start_button} = 3'h0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h1;
      {s_axi_arvalid, s_axi_rready, stuck, drop_x} = 4'h4;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
      s_axi_wstrb = 4'hf;
      {safety_interlock_ok, machine_protection_ok} = 2'h3;
      {fx, fy} = 10'h18c;
      {cycles, err_total, n_tests} = 96'h0;
      cyc(2);
      reset_n <= 1'h1;
      rd(CTRL_OFFSET, d);
      chk("ctrl_reset", CTRL_RESET, d);
      rd(MON_TIME_OFFSET, d);
      chk("mon_reset", MON_TIME_RESET, d);
      rd(8'h40, d);
      chk("unmapped_resp", RESP_SLVERR, resp);
      chk("unmapped", 0, d);
      wr(MON_TIME_OFFSET, 32'h0000_0014);
      wr(IRQ_MASK_OFFSET, 32'h0000_007f);
      run_end();
      no_feedback();
      for (int k = 0; k < 4; k++)
         run_fault(2'(k));
      fy <= 5'h04;
      blocked(32'h0000_0002);
      fy <= 5'h08;
      blocked(32'h0000_0002);
      {safety_interlock_ok, fx} <= 6'h0d;
      blocked(32'h0000_0005);
      {machine_protection_ok, local_start_button} <= 2'h1;
      blocked(32'h0000_000d);
      jog();
      conclude();
   end
endmodule : bidirectional_drive_supervisor_tb_top

// *** sim/drive_checker_asserts.sv ***
`timescale 1ns/100ps
module drive_checker
   import drive_supervisor_pkg::*;
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic dir_run_feedback_x,
   input wire logic dir_torque_permissive_x,
   input wire logic dir_torque_permissive_y,
   input wire logic dir_end_position_x,
   input wire logic safety_interlock_ok,
   input wire logic dir_run_command_x,
   input wire logic dir_run_command_y,
   input wire logic failed,
   input wire logic irq
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!reset_n);

   fail_quiet_a: assert property (
      failed |-> !dir_run_command_x && !dir_run_command_y)
      else $error("command high while failed");
   one_dir_a: assert property (
      !(dir_run_command_x && dir_run_command_y))
      else $error("both direction commands high");
   safety_hold_a: assert property (
      !safety_interlock_ok [*5] |-> !dir_run_command_x && !dir_run_command_y)
      else $error("running without safety interlock");
   torque_hold_a: assert property (
      !dir_torque_permissive_y [*5] |-> !dir_run_command_y)
      else $error("running y without torque permissive");
   end_stop_a: assert property (
      dir_end_position_x [*5] |-> !dir_run_command_x)
      else $error("travel x past end position");
   fb_lost_a: assert property (
      $fell(dir_run_feedback_x) && dir_run_command_x |-> ##[1:5] failed)
      else $error("feedback loss not failed");
   torque_drop_a: assert property (
      $fell(dir_torque_permissive_x) && dir_run_feedback_x |-> ##[1:5] failed)
      else $error("torque drop while running not failed");
   safety_drop_a: assert property (
      $fell(safety_interlock_ok) && (dir_run_command_x || dir_run_command_y)
      |-> ##[1:5] failed)
      else $error("safety drop while active not failed");

   cover property ($rose(failed));
   cover property ($rose(dir_run_command_x));
   cover property ($rose(irq));
endmodule : drive_checker

bind bidirectional_drive_supervisor drive_checker checker_i (.*);

// *** sim/field_contactors.sv ***
`timescale 1ns/100ps
module field_contactors
   import drive_supervisor_pkg::*;
#(
   parameter int LAG = 3
)(
   input  wire logic clk,
   input  wire logic cmd_x,
   input  wire logic cmd_y,
   input  wire logic stuck,
   input  wire logic drop_x,
   output logic      fb_x,
   output logic      fb_y
);
   logic [LAG-1:0] sx_q;
   logic [LAG-1:0] sy_q;

   // contactor closes some cycles after its coil
   always_ff @(posedge clk)
   begin
      sx_q <= {sx_q[LAG-2:0], cmd_x};
      sy_q <= {sy_q[LAG-2:0], cmd_y};
   end

   // contact opens with coil, or on demand when stuck (both) or dropped (x only)
   assign fb_x = sx_q[LAG-1] & cmd_x & !stuck & !drop_x;
   assign fb_y = sy_q[LAG-1] & cmd_y & !stuck;
endmodule : field_contactors

// *** src/axi_lite_regs.sv ***
`timescale 1ns/100ps
module axi_lite_regs
   import drive_supervisor_pkg::*;
(
   input  wire logic                 clk,
   input  wire logic                 reset_n,
   input  wire logic [7:0]           s_axi_awaddr,
   input  wire logic                 s_axi_awvalid,
   output logic                      s_axi_awready,
   input  wire logic [31:0]          s_axi_wdata,
   input  wire logic [3:0]           s_axi_wstrb,
   input  wire logic                 s_axi_wvalid,
   output logic                      s_axi_wready,
   output logic [1:0]                s_axi_bresp,
   output logic                      s_axi_bvalid,
   input  wire logic                 s_axi_bready,
   input  wire logic [7:0]           s_axi_araddr,
   input  wire logic                 s_axi_arvalid,
   output logic                      s_axi_arready,
   output logic [31:0]               s_axi_rdata,
   output logic [1:0]                s_axi_rresp,
   output logic                      s_axi_rvalid,
   input  wire logic                 s_axi_rready,
   input  wire logic [31:0]          status_word,
   input  wire logic [EV_WIDTH-1:0]  events,
   output drive_ctrl_type            ctrl,
   output logic                      irq
);
   logic [31:0]          ctrl_q;
   logic [31:0]          mon_q;
   logic [EV_WIDTH-1:0]  ev_q;
   logic [EV_WIDTH-1:0]  mask_q;
   logic                 restart_q;
   logic                 aw_got_q;
   logic                 w_got_q;
   logic [7:0]           awaddr_q;
   logic [31:0]          wdata_q;
   logic [3:0]           wstrb_q;

   function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0]  st);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++)
         if (st[i])
            r[i*8 +: 8] = nw[i*8 +: 8];
      return r;
   endfunction : merge

   wire logic do_write = aw_got_q && w_got_q && !s_axi_bvalid;
   wire logic wr_ctrl  = do_write && awaddr_q == CTRL_OFFSET;
   wire logic wr_stat  = do_write && awaddr_q == IRQ_STAT_OFFSET;
   wire logic wr_mask  = do_write && awaddr_q == IRQ_MASK_OFFSET;
   wire logic wr_mon   = do_write && awaddr_q == MON_TIME_OFFSET;
   wire logic wr_hit   = wr_ctrl || wr_stat || wr_mask || wr_mon ||
                         awaddr_q == STATUS_OFFSET;
   wire logic [31:0] ctrl_new = merge(ctrl_q, wdata_q, wstrb_q);
   wire logic [31:0] mask_new = merge(32'(mask_q), wdata_q, wstrb_q);
   wire logic [EV_WIDTH-1:0] ev_clr =
      wr_stat ? wdata_q[EV_WIDTH-1:0] & {EV_WIDTH{wstrb_q[0]}} : '0;
   wire logic rd_hit = s_axi_araddr == CTRL_OFFSET ||
      s_axi_araddr == STATUS_OFFSET || s_axi_araddr == IRQ_STAT_OFFSET ||
      s_axi_araddr == IRQ_MASK_OFFSET || s_axi_araddr == MON_TIME_OFFSET;
   wire logic [31:0] rd_mux =
      s_axi_araddr == CTRL_OFFSET     ? ctrl_q :
      s_axi_araddr == STATUS_OFFSET   ? status_word :
      s_axi_araddr == IRQ_STAT_OFFSET ? 32'(ev_q) :
      s_axi_araddr == IRQ_MASK_OFFSET ? 32'(mask_q) :
      s_axi_araddr == MON_TIME_OFFSET ? mon_q : 32'h0000_0000;

   // next held and answer state, so that each ready comes from a flop
   wire logic aw_nx = !do_write &&
                      (aw_got_q || (s_axi_awvalid && s_axi_awready));
   wire logic w_nx  = !do_write &&
                      (w_got_q || (s_axi_wvalid && s_axi_wready));
   wire logic b_nx  = do_write || (s_axi_bvalid && !s_axi_bready);
   wire logic r_nx  = (s_axi_arvalid && s_axi_arready) ||
                      (s_axi_rvalid && !s_axi_rready);

   assign ctrl.request_x             = ctrl_q[CTRL_REQ_X_BIT];
   assign ctrl.request_y             = ctrl_q[CTRL_REQ_Y_BIT];
   assign ctrl.local_mode            = ctrl_q[CTRL_LOCAL_BIT];
   assign ctrl.jog_disable_param     = ctrl_q[CTRL_JOG_DIS_BIT];
   assign ctrl.restart               = restart_q;
   assign ctrl.feedback_monitor_time = mon_q;

   always_ff @(posedge clk)
   begin
      if (!reset_n)
      begin
         aw_got_q     <= 1'b0;
         w_got_q      <= 1'b0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_arready <= 1'b0;
         awaddr_q     <= 8'h00;
         wdata_q      <= 32'h0000_0000;
         wstrb_q      <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= RESP_OKAY;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= RESP_OKAY;
         ctrl_q       <= CTRL_RESET;
         mon_q        <= MON_TIME_RESET;
         mask_q       <= IRQ_MASK_RESET[EV_WIDTH-1:0];
         ev_q         <= '0;
         restart_q    <= 1'b0;
         irq          <= 1'b0;
      end
      else
      begin
         s_axi_awready <= !aw_nx && !b_nx;
         s_axi_wready  <= !w_nx && !b_nx;
         s_axi_arready <= !r_nx;
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_got_q <= 1'b1;
            awaddr_q <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_got_q <= 1'b1;
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
         end
         if (do_write)
         begin
            aw_got_q     <= 1'b0;
            w_got_q      <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
         end
         else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
         // restart bit self-clears: a one-cycle pulse to the supervisor
         restart_q <= wr_ctrl && wstrb_q[0] && wdata_q[CTRL_RESTART_BIT];
         if (wr_ctrl)
            ctrl_q <= ctrl_new & 32'h0000_000f;
         if (wr_mon)
            mon_q <= merge(mon_q, wdata_q, wstrb_q);
         if (wr_mask)
            mask_q <= mask_new[EV_WIDTH-1:0];
         // set wins over write-one-to-clear
         ev_q <= (ev_q & ~ev_clr) | events;
         irq  <= |(((ev_q & ~ev_clr) | events) & mask_q);
         if (s_axi_arvalid && s_axi_arready)
         begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_mux;
            s_axi_rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
         end
         else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
      end
   end
endmodule : axi_lite_regs

// *** src/bidirectional_drive_supervisor.sv ***
// The implementer's own choices: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/100ps
// Notes on behaviour
// - feedback must follow command within monitor time
// - feedback lost while running fails until restart
// - torque permissive required to start or run
// - torque drop during running feedback fails
// - internal limit permissive required per direction
// - limit drop during running feedback fails
// - end position high stops travel normally
// - safety interlock required; drop while running fails
// - safety interlock never bypassed
// - local start button bridges machine protection
// - bridging only when jog disable is zero
// - one command output per direction
module bidirectional_drive_supervisor
   import drive_supervisor_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        reset_n,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic        parent_group_restart,
   input  wire logic        dir_run_feedback_x,
   input  wire logic        dir_run_feedback_y,
   input  wire logic        dir_torque_permissive_x,
   input  wire logic        dir_torque_permissive_y,
   input  wire logic        dir_limit_permissive_x,
   input  wire logic        dir_limit_permissive_y,
   input  wire logic        dir_end_position_x,
   input  wire logic        dir_end_position_y,
   input  wire logic        local_start_button,
   input  wire logic        local_start_button_dir_x,
   input  wire logic        local_start_button_dir_y,
   input  wire logic        safety_interlock_ok,
   input  wire logic        machine_protection_ok,
   output logic             dir_run_command_x,
   output logic             dir_run_command_y,
   output logic             failed,
   output logic             irq
);
   localparam int NPIN = 14;

   logic [NPIN-1:0]     pins_raw;
   logic [NPIN-1:0]     pins_s;
   dir_field_type       fx;
   dir_field_type       fy;
   logic                common_button;
   logic                safety_s;
   logic                machine_s;
   logic                restart_pin_s;
   drive_ctrl_type      ctrl;
   drive_state_type     state_q;
   drive_state_type     state_d;
   logic                dir_y_q;
   logic                dir_y_d;
   logic [31:0]         timer_q;
   logic                torque_prev_q;
   logic                limit_prev_q;
   logic                safety_prev_q;
   logic [EV_WIDTH-1:0] events;
   logic [31:0]         status_word;
   logic                cmd_x_d;
   logic                cmd_y_d;

   assign pins_raw = {parent_group_restart, safety_interlock_ok,
      machine_protection_ok, local_start_button,
      dir_run_feedback_x, dir_torque_permissive_x,
      dir_limit_permissive_x, dir_end_position_x,
      local_start_button_dir_x,
      dir_run_feedback_y, dir_torque_permissive_y,
      dir_limit_permissive_y, dir_end_position_y,
      local_start_button_dir_y};

   input_sync #(.WIDTH(NPIN)) u_sync (
      .clk      (clk),
      .reset_n  (reset_n),
      .async_in (pins_raw),
      .sync_out (pins_s)
   );

   assign {restart_pin_s, safety_s, machine_s, common_button} = pins_s[13:10];
   assign fx = pins_s[9:5];
   assign fy = pins_s[4:0];

   axi_lite_regs u_regs (
      .clk           (clk),
      .reset_n       (reset_n),
      .s_axi_awaddr  (s_axi_awaddr),
      .s_axi_awvalid (s_axi_awvalid),
      .s_axi_awready (s_axi_awready),
      .s_axi_wdata   (s_axi_wdata),
      .s_axi_wstrb   (s_axi_wstrb),
      .s_axi_wvalid  (s_axi_wvalid),
      .s_axi_wready  (s_axi_wready),
      .s_axi_bresp   (s_axi_bresp),
      .s_axi_bvalid  (s_axi_bvalid),
      .s_axi_bready  (s_axi_bready),
      .s_axi_araddr  (s_axi_araddr),
      .s_axi_arvalid (s_axi_arvalid),
      .s_axi_arready (s_axi_arready),
      .s_axi_rdata   (s_axi_rdata),
      .s_axi_rresp   (s_axi_rresp),
      .s_axi_rvalid  (s_axi_rvalid),
      .s_axi_rready  (s_axi_rready),
      .status_word   (status_word),
      .events        (events),
      .ctrl          (ctrl),
      .irq           (irq)
   );

   function automatic logic may_run(input dir_field_type f,
                                     input logic safety,
                                     input logic machine,
                                     input logic bridge);
      return f.torque_permissive && f.limit_permissive &&
             !f.end_position && safety && (machine || bridge);
   endfunction : may_run

   wire logic bridge_x = ctrl.local_mode && !ctrl.jog_disable_param &&
                         (common_button || fx.local_start_button);
   wire logic bridge_y = ctrl.local_mode && !ctrl.jog_disable_param &&
                         (common_button || fy.local_start_button);
   wire logic ok_x = may_run(fx, safety_s, machine_s, bridge_x);
   wire logic ok_y = may_run(fy, safety_s, machine_s, bridge_y);
   wire logic want_x = ctrl.request_x && !ctrl.request_y;
   wire logic want_y = ctrl.request_y && !ctrl.request_x;
   wire logic restart = ctrl.restart || restart_pin_s;

   wire dir_field_type fa = dir_y_q ? fy : fx;
   wire logic ok_a   = dir_y_q ? ok_y : ok_x;
   wire logic want_a = dir_y_q ? want_y : want_x;
   wire logic active = state_q == ST_STARTING || state_q == ST_RUNNING;
   wire logic timeout = state_q == ST_STARTING && !fa.run_feedback &&
                        timer_q >= ctrl.feedback_monitor_time;
   wire logic fb_lost = state_q == ST_RUNNING && !fa.run_feedback;
   wire logic torque_fall = active && fa.run_feedback && torque_prev_q &&
                            !fa.torque_permissive;
   wire logic limit_fall = active && fa.run_feedback && limit_prev_q &&
                           !fa.limit_permissive;
   wire logic safety_fall = active && safety_prev_q && !safety_s;
   wire logic machine_fall = active && !machine_s &&
                             !(dir_y_q ? bridge_y : bridge_x);
   wire logic end_stop = active && fa.end_position;
   wire logic fault = timeout || fb_lost || torque_fall || limit_fall ||
                      safety_fall || machine_fall;

   assign events = {end_stop && !fault, machine_fall, safety_fall,
                    limit_fall, torque_fall, fb_lost, timeout};

   always_comb
   begin
      state_d = state_q;
      dir_y_d = dir_y_q;
      case (state_q)
         ST_IDLE:
         begin
            if (want_x && ok_x)
            begin
               state_d = ST_STARTING;
               dir_y_d = 1'b0;
            end
            else if (want_y && ok_y)
            begin
               state_d = ST_STARTING;
               dir_y_d = 1'b1;
            end
         end
         ST_STARTING, ST_RUNNING:
         begin
            if (fault)
               state_d = ST_FAILED;
            else if (!want_a || !ok_a)
               state_d = ST_IDLE;
            else if (state_q == ST_STARTING && fa.run_feedback)
               state_d = ST_RUNNING;
         end
         ST_FAILED:
         begin
            if (restart)
               state_d = ST_IDLE;
         end
         default:
            state_d = ST_IDLE;
      endcase
   end

   assign cmd_x_d = (state_d == ST_STARTING || state_d == ST_RUNNING) &&
                    !dir_y_d;
   assign cmd_y_d = (state_d == ST_STARTING || state_d == ST_RUNNING) &&
                    dir_y_d;

   assign status_word = {24'h00_0000, 2'b00,
      state_q == ST_FAILED, state_q == ST_RUNNING,
      state_q == ST_STARTING, dir_y_q, fy.run_feedback, fx.run_feedback};

   always_ff @(posedge clk)
   begin
      if (!reset_n)
      begin
         state_q           <= ST_IDLE;
         dir_y_q           <= 1'b0;
         timer_q           <= 32'h0000_0000;
         torque_prev_q     <= 1'b0;
         limit_prev_q      <= 1'b0;
         safety_prev_q     <= 1'b0;
         dir_run_command_x <= 1'b0;
         dir_run_command_y <= 1'b0;
         failed            <= 1'b0;
      end
      else
      begin
         state_q           <= state_d;
         dir_y_q           <= dir_y_d;
         timer_q           <= (state_d == ST_STARTING &&
                               state_q == ST_STARTING) ?
                              timer_q + 32'h0000_0001 : 32'h0000_0000;
         torque_prev_q     <= fa.torque_permissive;
         limit_prev_q      <= fa.limit_permissive;
         safety_prev_q     <= safety_s;
         dir_run_command_x <= cmd_x_d;
         dir_run_command_y <= cmd_y_d;
         failed            <= state_d == ST_FAILED;
      end
   end
endmodule : bidirectional_drive_supervisor

// *** src/input_sync.sv ***
`timescale 1ns/100ps
module input_sync
   import drive_supervisor_pkg::*;
#(
   parameter int WIDTH = 1
)(
   input  wire logic             clk,
   input  wire logic             reset_n,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_q;

   always_ff @(posedge clk)
   begin
      if (!reset_n)
      begin
         meta_q   <= '0;
         sync_out <= '0;
      end
      else
      begin
         meta_q   <= async_in;
         sync_out <= meta_q;
      end
   end
endmodule : input_sync
